// ### hdl/tcmu_top.sv
// Purpose: compare channel of a capture/compare unit, axi4-lite slave
// Assumes: software keeps timer synchronous and off the raw system clock
// Notes: timer ticks from aclk/4 or a synchronised external clock pin
module tcmu_top
  import tcmu_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_timer_clk,
  input wire logic adc_enabled,
  output logic match_output_pin,
  output logic match_output_pin_oe,
  output logic special_event_trigger,
  output logic adc_start,
  output logic irq
);

  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] off);
    addr_is = (a == ADDR_W'(off));
  endfunction : addr_is

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = addr_is(a, TCMU_OFF_CTRL) || addr_is(a, TCMU_OFF_CMPL) ||
             addr_is(a, TCMU_OFF_CMPH) || addr_is(a, TCMU_OFF_TMRL) ||
             addr_is(a, TCMU_OFF_TMRH) || addr_is(a, TCMU_OFF_TCFG) ||
             addr_is(a, TCMU_OFF_ISTAT) || addr_is(a, TCMU_OFF_ICLR) ||
             addr_is(a, TCMU_OFF_IEN);
  endfunction : mapped

  // register state
  logic [7:0] channel_control_r;
  logic [7:0] compare_value_low_r;
  logic [7:0] compare_value_high_r;
  logic [7:0] tcfg_r;
  logic [1:0] istat_r;
  logic [1:0] istat_nxt;
  logic [1:0] ien_r;
  logic [1:0] div_r;
  logic eq_prev_r;
  logic ext_prev_r;
  logic pin_latch_r;
  logic pin_latch_nxt;
  tcmu_sev_type sev_state_r;
  tcmu_sev_type sev_state_nxt;

  // write channel holding
  logic aw_full_r;
  logic w_full_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0] wbyte_r;
  logic wlane_r;

  // timer
  logic [15:0] timer_count;
  logic timer_overflow_flag;
  logic ext_level;
  logic tick;
  logic sev_reset;

  // decode
  logic aw_take;
  logic w_take;
  logic do_write;
  logic wr_ok;
  logic wr_ctrl;
  logic wr_cmpl;
  logic wr_cmph;
  logic wr_tmrl;
  logic wr_tmrh;
  logic wr_tcfg;
  logic wr_iclr;
  logic wr_ien;
  logic ar_take;
  logic [31:0] rd_word;

  // match logic
  logic [3:0] match_mode_field;
  logic [15:0] compare_value;
  logic eq;
  logic match;
  logic compare_mode;
  logic pin_mode;
  logic [1:0] irq_events;

  tcmu_sync u_ext_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(ext_timer_clk),
    .level_out(ext_level)
  );

  tcmu_timer #(
    .WIDTH(16)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .sev_reset(sev_reset),
    .load_lo(wr_tmrl),
    .load_hi(wr_tmrh),
    .load_data(wbyte_r),
    .count(timer_count),
    .overflow(timer_overflow_flag)
  );

  // timer clock source
  assign tick = tcfg_r[TCMU_TCFG_RUN] &&
                (tcfg_r[TCMU_TCFG_EXT] ? (ext_level && !ext_prev_r)
                                       : (div_r == TCMU_DIV_LAST));

  // write decode
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign do_write = aw_full_r && w_full_r && !s_axi_bvalid;
  assign wr_ok = do_write && wlane_r;
  assign wr_ctrl = wr_ok && addr_is(awaddr_r, TCMU_OFF_CTRL);
  assign wr_cmpl = wr_ok && addr_is(awaddr_r, TCMU_OFF_CMPL);
  assign wr_cmph = wr_ok && addr_is(awaddr_r, TCMU_OFF_CMPH);
  assign wr_tmrl = wr_ok && addr_is(awaddr_r, TCMU_OFF_TMRL);
  assign wr_tmrh = wr_ok && addr_is(awaddr_r, TCMU_OFF_TMRH);
  assign wr_tcfg = wr_ok && addr_is(awaddr_r, TCMU_OFF_TCFG);
  assign wr_iclr = wr_ok && addr_is(awaddr_r, TCMU_OFF_ICLR);
  assign wr_ien = wr_ok && addr_is(awaddr_r, TCMU_OFF_IEN);
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // read mux; clear register reads zero
  assign rd_word =
    addr_is(s_axi_araddr, TCMU_OFF_CTRL) ? {24'h000000, channel_control_r} :
    addr_is(s_axi_araddr, TCMU_OFF_CMPL) ? {24'h000000, compare_value_low_r} :
    addr_is(s_axi_araddr, TCMU_OFF_CMPH) ? {24'h000000, compare_value_high_r} :
    addr_is(s_axi_araddr, TCMU_OFF_TMRL) ? {24'h000000, timer_count[7:0]} :
    addr_is(s_axi_araddr, TCMU_OFF_TMRH) ? {24'h000000, timer_count[15:8]} :
    addr_is(s_axi_araddr, TCMU_OFF_TCFG) ? {24'h000000, tcfg_r} :
    addr_is(s_axi_araddr, TCMU_OFF_ISTAT) ? {30'h00000000, istat_r} :
    addr_is(s_axi_araddr, TCMU_OFF_IEN) ? {30'h00000000, ien_r} :
    32'h00000000;

  // compare
  assign match_mode_field = channel_control_r[3:0];
  assign compare_value = {compare_value_high_r, compare_value_low_r};
  assign eq = (compare_value == timer_count);
  assign compare_mode = (match_mode_field == TCMU_MODE_TOGGLE) ||
                        (match_mode_field[3:2] == 2'b10);
  assign match = compare_mode && eq && !eq_prev_r;
  assign pin_mode = (match_mode_field == TCMU_MODE_TOGGLE) ||
                    (match_mode_field == TCMU_MODE_SET) ||
                    (match_mode_field == TCMU_MODE_CLEAR);
  assign irq_events = {timer_overflow_flag, match};
  assign istat_nxt = (istat_r & ~({2{wr_iclr}} & wbyte_r[1:0])) |
                     irq_events;

  // special event: trigger now, reset at next timer tick if still equal
  assign sev_reset = (sev_state_r == TCMU_SEV_WAIT) && eq;

  always_comb begin
    sev_state_nxt = sev_state_r;
    case (sev_state_r)
      TCMU_SEV_IDLE: begin
        if (match && (match_mode_field == TCMU_MODE_SPECIAL)) begin
          sev_state_nxt = TCMU_SEV_WAIT;
        end
      end
      TCMU_SEV_WAIT: begin
        if (tick) begin
          sev_state_nxt = TCMU_SEV_IDLE;
        end
      end
      default: sev_state_nxt = TCMU_SEV_IDLE;
    endcase
  end

  always_comb begin
    pin_latch_nxt = pin_latch_r;
    if (wr_ctrl && (wbyte_r == 8'h00)) begin
      pin_latch_nxt = 1'b0;
    end else if (match) begin
      case (match_mode_field)
        TCMU_MODE_TOGGLE: pin_latch_nxt = !pin_latch_r;
        TCMU_MODE_SET: pin_latch_nxt = 1'b1;
        TCMU_MODE_CLEAR: pin_latch_nxt = 1'b0;
        default: pin_latch_nxt = pin_latch_r;
      endcase
    end
  end

  // channel state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eq_prev_r <= 1'b0;
      ext_prev_r <= 1'b0;
      div_r <= 2'h0;
      pin_latch_r <= 1'b0;
      sev_state_r <= TCMU_SEV_IDLE;
      istat_r <= TCMU_RST_IRQ;
      match_output_pin <= 1'b0;
      match_output_pin_oe <= 1'b0;
      special_event_trigger <= 1'b0;
      adc_start <= 1'b0;
      irq <= 1'b0;
    end else begin
      eq_prev_r <= eq && compare_mode;
      ext_prev_r <= ext_level;
      div_r <= div_r + 2'h1;
      pin_latch_r <= pin_latch_nxt;
      sev_state_r <= sev_state_nxt;
      istat_r <= istat_nxt;
      match_output_pin <= pin_latch_nxt;
      match_output_pin_oe <= pin_mode && !tcfg_r[TCMU_TCFG_DIR];
      special_event_trigger <= match &&
        (match_mode_field == TCMU_MODE_SPECIAL);
      adc_start <= match && adc_enabled &&
        (match_mode_field == TCMU_MODE_SPECIAL);
      irq <= |(istat_nxt & ien_r);
    end
  end

  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_control_r <= TCMU_RST_CTRL;
      compare_value_low_r <= TCMU_RST_CMP;
      compare_value_high_r <= TCMU_RST_CMP;
      tcfg_r <= TCMU_RST_TCFG;
      ien_r <= TCMU_RST_IRQ;
    end else begin
      if (wr_ctrl) begin
        channel_control_r <= wbyte_r;
      end
      if (wr_cmpl) begin
        compare_value_low_r <= wbyte_r;
      end
      if (wr_cmph) begin
        compare_value_high_r <= wbyte_r;
      end
      if (wr_tcfg) begin
        tcfg_r <= {5'h00, wbyte_r[2:0]};
      end
      if (wr_ien) begin
        ien_r <= wbyte_r[1:0];
      end
    end
  end

  // axi write channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= '0;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TCMU_RESP_OKAY;
    end else begin
      aw_full_r <= (aw_full_r || aw_take) && !do_write;
      w_full_r <= (w_full_r || w_take) && !do_write;
      s_axi_awready <= !((aw_full_r || aw_take) && !do_write);
      s_axi_wready <= !((w_full_r || w_take) && !do_write);
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wbyte_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_r) ? TCMU_RESP_OKAY : TCMU_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= TCMU_RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= mapped(s_axi_araddr) ? TCMU_RESP_OKAY
                                            : TCMU_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : tcmu_top

// ### hdl/tcmu_pkg.sv
// Purpose: constants shared by the compare match unit
// Assumes: 32-bit axi4-lite data, one aligned word per register
// Notes: registers are at most 8 bits wide (status and enable are 2 bits), upper bits read zero
package tcmu_pkg;

  // register byte offsets
  localparam logic [7:0] TCMU_OFF_CTRL = 8'h00;
  localparam logic [7:0] TCMU_OFF_CMPL = 8'h04;
  localparam logic [7:0] TCMU_OFF_CMPH = 8'h08;
  localparam logic [7:0] TCMU_OFF_TMRL = 8'h0c;
  localparam logic [7:0] TCMU_OFF_TMRH = 8'h10;
  localparam logic [7:0] TCMU_OFF_TCFG = 8'h14;
  localparam logic [7:0] TCMU_OFF_ISTAT = 8'h18;
  localparam logic [7:0] TCMU_OFF_ICLR = 8'h1c;
  localparam logic [7:0] TCMU_OFF_IEN = 8'h20;

  // match_mode_field encodings
  localparam logic [3:0] TCMU_MODE_OFF = 4'h0;
  localparam logic [3:0] TCMU_MODE_TOGGLE = 4'h2;
  localparam logic [3:0] TCMU_MODE_SET = 4'h8;
  localparam logic [3:0] TCMU_MODE_CLEAR = 4'h9;
  localparam logic [3:0] TCMU_MODE_SWIRQ = 4'ha;
  localparam logic [3:0] TCMU_MODE_SPECIAL = 4'hb;

  // field positions
  localparam int TCMU_TCFG_RUN = 0;
  localparam int TCMU_TCFG_EXT = 1;
  localparam int TCMU_TCFG_DIR = 2;
  localparam int TCMU_IRQ_MATCH = 0;
  localparam int TCMU_IRQ_OVF = 1;

  // reset values
  localparam logic [7:0] TCMU_RST_CTRL = 8'h00;
  localparam logic [7:0] TCMU_RST_CMP = 8'h00;
  localparam logic [7:0] TCMU_RST_TCFG = 8'h04;
  localparam logic [1:0] TCMU_RST_IRQ = 2'h0;
  localparam logic [15:0] TCMU_RST_TMR = 16'h0000;

  // instruction clock is the system clock divided by four
  localparam int TCMU_INSN_DIV = 4;
  localparam logic [1:0] TCMU_DIV_LAST = 2'(TCMU_INSN_DIV - 1);

  // axi responses
  localparam logic [1:0] TCMU_RESP_OKAY = 2'h0;
  localparam logic [1:0] TCMU_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TCMU_SEV_IDLE = 2'b01,
    TCMU_SEV_WAIT = 2'b10
  } tcmu_sev_type;

endpackage : tcmu_pkg

// ### hdl/tcmu_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to aclk
// Notes: level changes once stages two and three agree
module tcmu_sync
  import tcmu_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic async_in,
  output logic level_out
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_out <= s3_r;
      end
    end
  end

endmodule : tcmu_sync

// ### hdl/tcmu_timer.sv
// Purpose: 16-bit timer counting on tick strobes
// Assumes: tick is a one-cycle pulse per timer clock edge
// Notes: special-event reset takes priority over counting
module tcmu_timer
  import tcmu_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic sev_reset,
  input wire logic load_lo,
  input wire logic load_hi,
  input wire logic [7:0] load_data,
  output logic [WIDTH-1:0] count,
  output logic overflow
);

  logic wrap;
  assign wrap = tick && !sev_reset && !load_lo && !load_hi &&
                (count == {WIDTH{1'b1}});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= TCMU_RST_TMR[WIDTH-1:0];
      overflow <= 1'b0;
    end else begin
      overflow <= wrap;
      if (load_lo) begin
        count[7:0] <= load_data;
      end else if (load_hi) begin
        count[WIDTH-1:8] <= load_data[WIDTH-9:0];
      end else if (tick && sev_reset) begin
        count <= '0;
      end else if (tick) begin
        count <= count + 1'b1;
      end
    end
  end

endmodule : tcmu_timer

// ### test/tcmu_sva.sv
// Purpose: port checker for the compare match unit
// Assumes: one aclk domain, aresetn synchronous active low
// Notes: bound to tcmu_top below
module tcmu_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic adc_enabled,
  input wire logic match_output_pin_oe,
  input wire logic special_event_trigger,
  input wire logic adc_start,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sev_single_a: assert property (
    special_event_trigger |=> !special_event_trigger [*3])
    else $error("trigger repeated inside one timer tick");
  adc_pair_a: assert property (
    adc_start |-> special_event_trigger)
    else $error("conversion start without trigger");
  adc_follow_a: assert property (
    special_event_trigger |-> adc_start == $past(adc_enabled))
    else $error("conversion start ignores converter enable");
  sev_nodrive_a: assert property (
    special_event_trigger |-> !match_output_pin_oe)
    else $error("pin driven in special event mode");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  rst_quiet_a: assert property (disable iff (1'b0)
    !aresetn |=> !irq && !special_event_trigger && !s_axi_bvalid)
    else $error("outputs active after reset");
endmodule : tcmu_sva

bind tcmu_top tcmu_sva tcmu_sva_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .adc_enabled(adc_enabled), .match_output_pin_oe(match_output_pin_oe),
  .special_event_trigger(special_event_trigger), .adc_start(adc_start),
  .irq(irq));

// ### test/tcmu_load.sv
// Purpose: external load on the compare pin
// Assumes: line has a pull-down
// Notes: undriven line reads low
module tcmu_load (
  input wire logic match_output_pin,
  input wire logic match_output_pin_oe,
  output logic pin_line
);
  assign pin_line = match_output_pin_oe ? match_output_pin : 1'b0;
endmodule : tcmu_load

// ### test/tcmu_tb_top.sv
// Purpose: self-checking bench for the compare match unit
// Assumes: external timer clock driven by the bench
// Notes: random compare values and modes, fixed seed
module tcmu_tb_top
  import tcmu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, ext_timer_clk = 1'b0, adc_enabled = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, bresp_v, rresp_v;
  logic match_output_pin, match_output_pin_oe, special_event_trigger;
  logic adc_start, irq, pin_line, p;
  logic [15:0] c;
  logic [3:0] m;
  logic [3:0] modes [4] = '{TCMU_MODE_TOGGLE, TCMU_MODE_SET, TCMU_MODE_CLEAR,
    TCMU_MODE_SWIRQ};
  int error_cnt = 0, n_tests = 0, cyc = 0, sev_cnt = 0, adc_cnt = 0, k;

  tcmu_top tcmu_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ext_timer_clk(ext_timer_clk),
    .adc_enabled(adc_enabled), .match_output_pin(match_output_pin),
    .match_output_pin_oe(match_output_pin_oe),
    .special_event_trigger(special_event_trigger), .adc_start(adc_start),
    .irq(irq));
  tcmu_load tcmu_load_i (.match_output_pin(match_output_pin),
    .match_output_pin_oe(match_output_pin_oe), .pin_line(pin_line));

  initial forever #5 aclk = ~aclk;

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  always @(posedge aclk) begin
    cyc++;
    sev_cnt += 32'(special_event_trigger);
    adc_cnt += 32'(adc_start);
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      $display("unexpected %s: expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, d);
    logic aw, w, h;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'($urandom_range(0, 1));
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w = 1'b1;
      end
    end
    do begin
      @(posedge aclk);
      h = s_axi_bvalid && s_axi_bready;
      if (s_axi_bvalid && !h) s_axi_bready <= 1'b1;
    end while (!h);
    bresp_v = s_axi_bresp;
  endtask : wr

  task automatic rchk(input string n, input logic [7:0] a, logic [31:0] e);
    logic h;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'($urandom_range(0, 1));
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      h = s_axi_rvalid && s_axi_rready;
      if (s_axi_rvalid && !h) s_axi_rready <= 1'b1;
    end while (!h);
    rd_v = s_axi_rdata;
    rresp_v = s_axi_rresp;
    chk(n, rd_v, e);
  endtask : rchk

  task automatic tick();
    ext_timer_clk <= 1'b1;
    repeat (10) @(posedge aclk);
    ext_timer_clk <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask : tick

  // park in interrupt-only mode, timer one below compare, then one tick
  task automatic hit(input logic [3:0] md, input logic [15:0] cv);
    wr(TCMU_OFF_CTRL, {4'h0, TCMU_MODE_SWIRQ});
    wr(TCMU_OFF_CMPL, cv[7:0]);
    wr(TCMU_OFF_CMPH, cv[15:8]);
    wr(TCMU_OFF_TMRL, 8'(cv - 16'h1));
    wr(TCMU_OFF_TMRH, 8'((cv - 16'h1) >> 8));
    wr(TCMU_OFF_ICLR, 8'h03);
    wr(TCMU_OFF_CTRL, {4'h0, md});
    sev_cnt = 0;
    adc_cnt = 0;
    tick();
  endtask : hit

  function automatic logic xpin(input logic [3:0] md, input logic q);
    case (md)
      TCMU_MODE_TOGGLE: return ~q;
      TCMU_MODE_SET: return 1'b1;
      TCMU_MODE_CLEAR: return 1'b0;
      default: return q;
    endcase
  endfunction : xpin

  initial begin
    rd_v = $urandom(3686);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk("control", TCMU_OFF_CTRL, 32'(TCMU_RST_CTRL));
    rchk("compare high", TCMU_OFF_CMPH, 32'(TCMU_RST_CMP));
    rchk("timer config", TCMU_OFF_TCFG, 32'(TCMU_RST_TCFG));
    rchk("status", TCMU_OFF_ISTAT, 32'(TCMU_RST_IRQ));
    rchk("unmapped read", 8'h24, 32'h0);
    chk("unmapped rresp", 32'(rresp_v), 32'(TCMU_RESP_SLVERR));
    wr(8'h28, 8'h5a);
    chk("unmapped bresp", 32'(bresp_v), 32'(TCMU_RESP_SLVERR));
    s_axi_wstrb <= 4'h0;
    wr(TCMU_OFF_CMPH, 8'h5a);
    s_axi_wstrb <= 4'hf;
    chk("masked bresp", 32'(bresp_v), 32'(TCMU_RESP_OKAY));
    rchk("masked write", TCMU_OFF_CMPH, 32'(TCMU_RST_CMP));
    $display("test reset done");
    c = 16'($urandom_range(20, 50));
    wr(TCMU_OFF_CMPL, c[7:0]);
    wr(TCMU_OFF_CTRL, {4'h0, TCMU_MODE_TOGGLE});
    wr(TCMU_OFF_TCFG, 8'h01);
    k = 0;
    while (match_output_pin !== 1'b1 && k < 400) begin
      @(posedge aclk);
      k++;
    end
    repeat (8) @(posedge aclk);
    chk("toggled line", {31'h0, pin_line}, 32'h1);
    chk("masked irq", {31'h0, irq}, 32'h0);
    rchk("match flag", TCMU_OFF_ISTAT, 32'h1);
    wr(TCMU_OFF_IEN, 8'h01);
    repeat (2) @(posedge aclk);
    chk("enabled irq", {31'h0, irq}, 32'h1);
    wr(TCMU_OFF_ICLR, 8'h01);
    rchk("cleared flag", TCMU_OFF_ISTAT, 32'h0);
    chk("cleared irq", {31'h0, irq}, 32'h0);
    wr(TCMU_OFF_TCFG, 8'h03);
    p = 1'b1;
    $display("test internal clock done");
    for (int j = 0; j < 12; j++) begin
      m = (j < 4) ? modes[j] : modes[$urandom_range(0, 3)];
      c = 16'($urandom_range(1, 16'hfffe));
      hit(m, c);
      p = xpin(m, p);
      chk("pin latch", {31'h0, match_output_pin}, {31'h0, p});
      chk("pin drive", {31'h0, match_output_pin_oe},
        {31'h0, m != TCMU_MODE_SWIRQ});
      rchk("mode flag", TCMU_OFF_ISTAT, 32'h1);
    end
    $display("test modes done");
    hit(TCMU_MODE_SET, c);
    wr(TCMU_OFF_CTRL, 8'h00);
    repeat (2) @(posedge aclk);
    chk("cleared latch", {31'h0, match_output_pin}, 32'h0);
    for (int j = 0; j < 2; j++) begin
      adc_enabled <= j[0];
      c = 16'($urandom_range(1, 16'hfffe));
      hit(TCMU_MODE_SPECIAL, c);
      chk("trigger count", 32'(sev_cnt), 32'h1);
      chk("adc count", 32'(adc_cnt), 32'(j));
      rchk("timer held", TCMU_OFF_TMRL, {24'h0, c[7:0]});
      tick();
      rchk("timer reset low", TCMU_OFF_TMRL, 32'h0);
      rchk("timer reset high", TCMU_OFF_TMRH, 32'h0);
      rchk("overflow flag", TCMU_OFF_ISTAT, 32'h1);
    end
    hit(TCMU_MODE_SPECIAL, c);
    wr(TCMU_OFF_CMPL, c[7:0] ^ 8'h80);
    tick();
    rchk("timer kept", TCMU_OFF_TMRL, {24'h0, 8'(c + 16'h1)});
    $display("test special event done");
    stop_test();
  end
endmodule : tcmu_tb_top
